// file: sacs_adc_seq.v
// Converter clock select, conversion sequencing, abort and result registers
// Functional notes
// - Full conversion lasts 11.5 bit periods
// - Four clock sources: div2, div8, div32, RC
// - Select codes 00, 01, 10, 11
// - Two period gap, capacitor disconnected, after done
// - Done loads result, clears busy, sets flag
// - Clearing busy aborts; result kept
// - After abort wait two periods, then acquire
// - Analog pins read zero on port
// - Output pins still converted from driven level
// - Sequencing ignores channel and direction bits
// - Mid-run switch to a faster divisor shortens remaining bits
// - Acquisition identical for any resolution
// - Holding capacitor never discharged between conversions
// - RC typical period 4us standard, 6us extended
`timescale 1ns/1ps
`include "sacs_regs.vh"

module sacs_adc_seq #(
  parameter EXTENDED = 0,
  parameter RC_HALF_CYCLES = (EXTENDED ? `SACS_RC_TYP_EXT_NS : `SACS_RC_TYP_NS) / (2 * `SACS_CLK_NS)
) (
  // Clock and reset
  input wire i_clk,
  input wire i_srst,
  // Register port
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // Pins and comparator
  input wire [7:0] i_pin_in,
  input wire [7:0] i_pin_out,
  input wire i_cmp_high,
  // Analog front end control
  output reg o_sample_connect,
  output reg [2:0] o_mux_sel,
  output reg o_dac_load,
  output reg [9:0] o_dac_code,
  output reg o_done_flag,
  output reg o_busy
);

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // Analog pin mask per port configuration code
  function [7:0] analog_mask;
    input [3:0] cfg;
    begin
      case (cfg)
        4'h0: analog_mask = 8'hFF;
        4'h1: analog_mask = 8'hF7;
        4'h2: analog_mask = 8'h1F;
        4'h3: analog_mask = 8'h17;
        4'h4: analog_mask = 8'h0B;
        4'h5: analog_mask = 8'h03;
        4'h6, 4'h7: analog_mask = 8'h00;
        4'h8: analog_mask = 8'hF3;
        4'h9: analog_mask = 8'h3F;
        4'hA: analog_mask = 8'h37;
        4'hB: analog_mask = 8'h33;
        4'hC: analog_mask = 8'h13;
        4'hD: analog_mask = 8'h03;
        4'hE: analog_mask = 8'h01;
        default: analog_mask = 8'h01;
      endcase
    end
  endfunction

  function is_addr;
    input [3:0] a;
    input [3:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  // ----------------------------------------------------------------------------
  // States
  // ----------------------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_GAP = 2'h2;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [4:0] half_ff;
  reg [4:0] nxt_half;
  reg [7:0] ctrl_ff;
  reg [7:0] pcfg_ff;
  reg [7:0] dir_ff;
  reg [7:0] resh_ff;
  reg [7:0] resl_ff;
  reg ie_ff;
  reg [9:0] sar_ff;
  reg [3:0] bit_ff;
  reg [7:0] pin_meta_ff;
  reg [7:0] pin_sync_ff;
  reg cmp_meta_ff;
  reg cmp_sync_ff;
  wire half_tick;
  wire wr_ctrl;
  wire pwr;
  wire go_clear;
  wire go_set;
  wire conv_end;
  wire div_run;

  assign wr_ctrl = i_wr && is_addr(i_addr, `SACS_ADDR_CTRL);
  assign pwr = ctrl_ff[`SACS_CTRL_PWR];
  // Start only honoured while powered; refused in the gap so no stale start bit lingers
  assign go_set = wr_ctrl && i_wdata[`SACS_CTRL_GO] && pwr && i_wdata[`SACS_CTRL_PWR] && (state_ff != ST_GAP);
  assign go_clear = wr_ctrl && (!i_wdata[`SACS_CTRL_GO] || !i_wdata[`SACS_CTRL_PWR]);
  assign conv_end = (state_ff == ST_CONV) && half_tick && (half_ff == `SACS_CONV_HALVES - 5'h01);
  // Abort restarts the divider, so the recovery gap is two whole periods
  assign div_run = (state_ff == ST_GAP) || ((state_ff == ST_CONV) && ((nxt_state == ST_CONV) || conv_end));

  // ----------------------------------------------------------------------------
  // Bit clock
  // ----------------------------------------------------------------------------
  sacs_tad_gen #(
    .RC_HALF_CYCLES(RC_HALF_CYCLES)
  ) u_tad (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_run(div_run),
    .i_sel(ctrl_ff[`SACS_CTRL_CS_HI:`SACS_CTRL_CS_LO]),
    .o_half_tick(half_tick)
  );

  // ----------------------------------------------------------------------------
  // Synchronisers for pins and comparator
  // ----------------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_srst) begin
      pin_meta_ff <= 8'h00;
      pin_sync_ff <= 8'h00;
      cmp_meta_ff <= 1'b0;
      cmp_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= i_pin_in;
      pin_sync_ff <= pin_meta_ff;
      cmp_meta_ff <= i_cmp_high;
      cmp_sync_ff <= cmp_meta_ff;
    end
  end

  // ----------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------
  // Channel and direction bits never gate the sequence
  always @* begin
    nxt_state = state_ff;
    nxt_half = half_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_half = 5'h00;
        if (go_set) begin
          nxt_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (go_clear || !pwr) begin
          nxt_state = ST_GAP;
          nxt_half = 5'h00;
        end else if (conv_end) begin
          nxt_state = ST_GAP;
          nxt_half = 5'h00;
        end else if (half_tick) begin
          nxt_half = half_ff + 5'h01;
        end
      end
      ST_GAP: begin
        if (half_tick && half_ff == `SACS_GAP_HALVES - 5'h01) begin
          nxt_state = ST_IDLE;
          nxt_half = 5'h00;
        end else if (half_tick) begin
          nxt_half = half_ff + 5'h01;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_half = 5'h00;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      state_ff <= ST_IDLE;
      half_ff <= 5'h00;
    end else begin
      state_ff <= nxt_state;
      half_ff <= nxt_half;
    end
  end

  // ----------------------------------------------------------------------------
  // Successive approximation: one bit per period after the first period
  // ----------------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_srst) begin
      sar_ff <= 10'h000;
      bit_ff <= 4'h0;
    end else if (state_ff != ST_CONV || nxt_state != ST_CONV) begin
      sar_ff <= 10'h200;
      bit_ff <= `SACS_NUM_BITS;
    end else if (half_tick && half_ff[0] && half_ff != 5'h01 && bit_ff != 4'h0) begin
      // Decision on each full period; faster clock shortens later bits
      sar_ff[bit_ff - 4'h1] <= cmp_sync_ff;
      if (bit_ff > 4'h1) begin
        sar_ff[bit_ff - 4'h2] <= 1'b1;
      end
      bit_ff <= bit_ff - 4'h1;
    end
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_srst) begin
      ctrl_ff <= `SACS_CTRL_RST;
      pcfg_ff <= `SACS_PCFG_RST;
      dir_ff <= `SACS_DIR_RST;
      resh_ff <= 8'h00;
      resl_ff <= 8'h00;
      ie_ff <= 1'b0;
      o_done_flag <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= {i_wdata[7:3], go_set, 1'b0, i_wdata[`SACS_CTRL_PWR]};
      end else if (conv_end) begin
        ctrl_ff[`SACS_CTRL_GO] <= 1'b0;
      end
      if (i_wr && is_addr(i_addr, `SACS_ADDR_PCFG)) begin
        pcfg_ff <= {2'h0, i_wdata[`SACS_PCFG_FMT], 1'b0, i_wdata[3:0]};
      end
      if (i_wr && is_addr(i_addr, `SACS_ADDR_DIR)) begin
        dir_ff <= i_wdata;
      end
      // Result only on normal end; aborts keep last value
      if (conv_end && !go_clear) begin
        // Last bit is already decided in the register by now
        if (pcfg_ff[`SACS_PCFG_FMT]) begin
          resh_ff <= {6'h00, sar_ff[9:8]};
          resl_ff <= sar_ff[7:0];
        end else begin
          resh_ff <= sar_ff[9:2];
          resl_ff <= {sar_ff[1:0], 6'h00};
        end
      end else begin
        if (i_wr && is_addr(i_addr, `SACS_ADDR_RESH)) begin
          resh_ff <= i_wdata;
        end
        if (i_wr && is_addr(i_addr, `SACS_ADDR_RESL)) begin
          resl_ff <= i_wdata;
        end
      end
      // Set wins over a software clear in the same cycle
      if (conv_end && !go_clear) begin
        o_done_flag <= 1'b1;
      end else if (i_wr && is_addr(i_addr, `SACS_ADDR_FLAG)) begin
        o_done_flag <= i_wdata[`SACS_FLAG_BIT];
      end
      if (i_wr && is_addr(i_addr, `SACS_ADDR_FLAG)) begin
        ie_ff <= i_wdata[`SACS_FLAG_IE];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Read port and front end outputs
  // ----------------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `SACS_ADDR_CTRL: o_rdata <= {ctrl_ff[7:3], ctrl_ff[`SACS_CTRL_GO], 1'b0, ctrl_ff[0]};
        `SACS_ADDR_PCFG: o_rdata <= pcfg_ff;
        `SACS_ADDR_RESH: o_rdata <= resh_ff;
        `SACS_ADDR_RESL: o_rdata <= resl_ff;
        `SACS_ADDR_FLAG: o_rdata <= {6'h00, ie_ff, o_done_flag};
        `SACS_ADDR_PORT: o_rdata <= pin_sync_ff & ~analog_mask(pcfg_ff[3:0]);
        `SACS_ADDR_DIR: o_rdata <= dir_ff;
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // Same acquisition path for every resolution; no discharge control exists
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_sample_connect <= 1'b0;
      o_mux_sel <= 3'h0;
      o_dac_load <= 1'b0;
      o_dac_code <= 10'h000;
      o_busy <= 1'b0;
    end else begin
      o_sample_connect <= pwr && (nxt_state == ST_IDLE);
      // Driven pins reach the mux too; the pad mixes the level in
      o_mux_sel <= ctrl_ff[`SACS_CTRL_CH_HI:`SACS_CTRL_CH_LO];
      o_dac_load <= (state_ff == ST_CONV);
      o_dac_code <= sar_ff;
      o_busy <= (nxt_state == ST_CONV);
    end
  end

endmodule // sacs_adc_seq

// file: sacs_regs.vh
// Register map, field layout and timing constants for the converter sequencer
`ifndef SACS_REGS_VH
`define SACS_REGS_VH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define SACS_ADDR_CTRL 4'h0
`define SACS_ADDR_PCFG 4'h1
`define SACS_ADDR_RESH 4'h2
`define SACS_ADDR_RESL 4'h3
`define SACS_ADDR_FLAG 4'h4
`define SACS_ADDR_PORT 4'h5
`define SACS_ADDR_DIR 4'h6

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define SACS_CTRL_CS_HI 7
`define SACS_CTRL_CS_LO 6
`define SACS_CTRL_CH_HI 5
`define SACS_CTRL_CH_LO 3
`define SACS_CTRL_GO 2
`define SACS_CTRL_PWR 0
`define SACS_CTRL_RST 8'h00
`define SACS_PCFG_RST 8'h00
`define SACS_DIR_RST 8'hFF
`define SACS_FLAG_BIT 0
`define SACS_FLAG_IE 1
`define SACS_PCFG_FMT 5

// ----------------------------------------------------------------------------
// Clock select encodings and divisors
// ----------------------------------------------------------------------------
`define SACS_CS_DIV2 2'h0
`define SACS_CS_DIV8 2'h1
`define SACS_CS_DIV32 2'h2
`define SACS_CS_RC 2'h3
`define SACS_HALF_DIV2 5'h00
`define SACS_HALF_DIV8 5'h03
`define SACS_HALF_DIV32 5'h0F

// ----------------------------------------------------------------------------
// Sequencing in half periods: 11.5 periods = 23 halves, gap 2 periods = 4
// ----------------------------------------------------------------------------
`define SACS_CONV_HALVES 5'h17
`define SACS_GAP_HALVES 5'h04
`define SACS_NUM_BITS 4'hA
`define SACS_RC_TYP_NS 4000
`define SACS_RC_TYP_EXT_NS 6000
`define SACS_CLK_NS 10

`endif

// file: sacs_tad_gen.v
// Per-bit conversion clock generator: half-period tick from oscillator or RC
`timescale 1ns/1ps
`include "sacs_regs.vh"

module sacs_tad_gen #(
  parameter RC_HALF_CYCLES = 200
) (
  // Clock and reset
  input wire i_clk,
  input wire i_srst,
  // Control
  input wire i_run,
  input wire [1:0] i_sel,
  // Half-period tick
  output reg o_half_tick
);

  // ----------------------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------------------
  reg [15:0] cnt_ff;
  reg [15:0] lim;
  reg [15:0] nxt_cnt;

  // Terminal count per source; RC stands in as a fixed-rate divider
  always @* begin
    case (i_sel)
      `SACS_CS_DIV2: lim = {11'h000, `SACS_HALF_DIV2};
      `SACS_CS_DIV8: lim = {11'h000, `SACS_HALF_DIV8};
      `SACS_CS_DIV32: lim = {11'h000, `SACS_HALF_DIV32};
      default: lim = RC_HALF_CYCLES[15:0] - 16'h0001;
    endcase
  end

  // Restart on idle; a mid-run divisor change applies at once to the count already under way
  always @* begin
    if (!i_run || cnt_ff >= lim) begin
      nxt_cnt = 16'h0000;
    end else begin
      nxt_cnt = cnt_ff + 16'h0001;
    end
  end

  // Count and tick registers
  always @(posedge i_clk) begin
    if (i_srst) begin
      cnt_ff <= 16'h0000;
      o_half_tick <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      o_half_tick <= i_run && (cnt_ff >= lim);
    end
  end

endmodule // sacs_tad_gen

// file: sacs_cmp_model.sv
// Comparator stand-in that weighs the selected input against the trial code
`timescale 1ns/1ps

module sacs_cmp_model (
  // Trial code and channel from the sequencer
  input wire logic [9:0] i_code,
  input wire logic [2:0] i_mux_sel,
  // Pin setup and analog level
  input wire logic [7:0] i_dir,
  input wire logic [7:0] i_pin_out,
  input wire logic [9:0] i_level,
  // Comparator decision
  output wire logic o_cmp_high
);
  // Output pins present their driven rail, so the rail gets converted
  wire [9:0] ain = i_dir[i_mux_sel] ? i_level : {10{i_pin_out[i_mux_sel]}};

  // Keep the trial bit when the input reaches it
  assign o_cmp_high = (ain >= i_code);
endmodule // sacs_cmp_model

// file: sacs_adc_seq_props.sv
// Concurrent checks on the converter sequencer ports
`timescale 1ns/1ps
`include "sacs_regs.vh"

module sacs_adc_seq_props #(
  parameter RC_HALF_CYCLES = 2
) (
  // Clock and reset
  input wire i_clk,
  input wire i_srst,
  // Register port
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  // Sequencer status
  input wire o_sample_connect,
  input wire o_done_flag,
  input wire o_busy
);
  // ---------------------------------------------------------------------------
  // Shadow of power and select, abort and clock switch markers
  // ---------------------------------------------------------------------------
  reg pwr_ff;
  reg [1:0] sel_ff;
  reg abrt_ff;
  reg chg_ff;
  reg [15:0] cnt_ff;
  wire ctrl_wr = i_wr && (i_addr == `SACS_ADDR_CTRL);
  wire go_wr = ctrl_wr && i_wdata[`SACS_CTRL_GO];
  wire [15:0] half = (sel_ff == `SACS_CS_DIV2) ? 16'h0001 : (sel_ff == `SACS_CS_DIV8) ? 16'h0004 :
                     (sel_ff == `SACS_CS_DIV32) ? 16'h0010 : 16'(RC_HALF_CYCLES);

  // Mid-run switches void the length check, so they are remembered
  always @(posedge i_clk) begin
    if (i_srst) begin
      pwr_ff <= 1'b0;
      sel_ff <= 2'h0;
      abrt_ff <= 1'b0;
      chg_ff <= 1'b0;
      cnt_ff <= 16'h0000;
    end else begin
      if (ctrl_wr) begin
        pwr_ff <= i_wdata[`SACS_CTRL_PWR];
        sel_ff <= i_wdata[7:6];
      end
      abrt_ff <= (ctrl_wr && o_busy && !(i_wdata[`SACS_CTRL_GO] && i_wdata[`SACS_CTRL_PWR])) ? 1'b1 :
                 (go_wr && !o_busy) ? 1'b0 : abrt_ff;
      chg_ff <= (ctrl_wr && o_busy && i_wdata[7:6] != sel_ff) ? 1'b1 : (go_wr && !o_busy) ? 1'b0 : chg_ff;
      cnt_ff <= o_busy ? cnt_ff + 16'h0001 : 16'h0000;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_start_when_on: assert property (go_wr && i_wdata[0] && pwr_ff && o_sample_connect && !o_busy |=> o_busy)
    else $error("start not taken");
  a_start_when_off: assert property (go_wr && !pwr_ff |=> !o_busy)
    else $error("start taken while off");
  a_off_stays_idle: assert property (!pwr_ff && !o_busy |=> !o_busy)
    else $error("sequence began while off");
  a_conv_length: assert property ($fell(o_busy) && !abrt_ff && !chg_ff |->
    (cnt_ff >= 16'h0016 * half) && (cnt_ff <= 16'h0018 * half + 16'h0004))
    else $error("conversion length off");
  a_done_flag_set: assert property ($fell(o_busy) && !abrt_ff |-> ##[0:1] o_done_flag)
    else $error("done flag missing");
  a_abort_quiet: assert property (ctrl_wr && o_busy && !i_wdata[2] && !o_done_flag |=>
    !o_busy && !o_done_flag ##1 !o_done_flag)
    else $error("abort misbehaved");
  a_gap_open: assert property ($fell(o_busy) |-> !o_sample_connect [*4])
    else $error("capacitor reconnected in gap");
  a_gap_close: assert property ($fell(o_busy) && pwr_ff |-> ##[4:120] o_sample_connect)
    else $error("acquisition did not resume");

  c_done: cover property ($fell(o_busy) && !abrt_ff);
  c_abort: cover property ($fell(o_busy) && abrt_ff);
  c_switch: cover property ($fell(o_busy) && chg_ff);
endmodule // sacs_adc_seq_props

bind sacs_adc_seq sacs_adc_seq_props #(.RC_HALF_CYCLES(RC_HALF_CYCLES)) sacs_adc_seq_props_inst (
  .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .o_sample_connect(o_sample_connect), .o_done_flag(o_done_flag), .o_busy(o_busy));

// file: tb_sar_adc_clock_and_sequencing.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`include "sacs_regs.vh"

module tb_sar_adc_clock_and_sequencing;
  localparam int RC_H = 2;
  logic i_clk, i_srst, i_wr, i_rd;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, i_pin_in, i_pin_out, dir;
  logic [9:0] level;
  wire [7:0] o_rdata;
  wire [9:0] o_dac_code;
  wire [2:0] o_mux_sel;
  wire i_cmp_high, o_sample_connect, o_dac_load, o_done_flag, o_busy;
  int error_cnt, checks_done, n, h;

  // Short RC half period keeps the run brief
  sacs_adc_seq #(.RC_HALF_CYCLES(RC_H)) sacs_adc_seq_inst (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_in(i_pin_in), .i_pin_out(i_pin_out),
    .i_cmp_high(i_cmp_high), .o_sample_connect(o_sample_connect), .o_mux_sel(o_mux_sel), .o_dac_load(o_dac_load),
    .o_dac_code(o_dac_code), .o_done_flag(o_done_flag), .o_busy(o_busy));
  sacs_cmp_model sacs_cmp_model_inst (.i_code(o_dac_code), .i_mux_sel(o_mux_sel), .i_dir(dir),
    .i_pin_out(i_pin_out), .i_level(level), .o_cmp_high(i_cmp_high));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ---------------------------------------------------------------------------
  // Access and compare tasks
  // ---------------------------------------------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Gap cycle after each strobe avoids re-driving it in one step
  task wr(input logic [3:0] a, input logic [7:0] d);
    i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
    @(posedge i_clk); i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    i_addr <= a; i_rd <= 1'b1;
    @(posedge i_clk); i_rd <= 1'b0;
    @(negedge i_clk); chk({8'h00, o_rdata}, {8'h00, e});
    @(posedge i_clk);
  endtask
  // Counts busy cycles from the start write, then waits out the gap
  task busy_len(output int c);
    c = 1;
    while (c < 2000) begin
      @(negedge i_clk);
      if (o_busy !== 1'b1) break;
      c++;
    end
    repeat (100) @(posedge i_clk);
  endtask
  task convert(input logic [1:0] s, input logic [2:0] ch);
    wr(`SACS_ADDR_CTRL, {s, ch, 3'h1});
    repeat (8) @(posedge i_clk);
    wr(`SACS_ADDR_CTRL, {s, ch, 3'h5});
    busy_len(n);
  endtask
  task wrap_up;
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #300000;
    error_cnt++;
    wrap_up;
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    i_srst = 1'b1; i_addr = 4'h0; i_wdata = 8'h00; i_wr = 1'b0; i_rd = 1'b0;
    i_pin_in = 8'hFF; i_pin_out = 8'h20; dir = 8'hFF; level = 10'h000;
    error_cnt = 0; checks_done = 0;
    repeat (5) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    rd(`SACS_ADDR_CTRL, 8'h00);
    rd(`SACS_ADDR_DIR, 8'hFF);
    wr(`SACS_ADDR_CTRL, 8'h04);
    #1 chk(o_busy, 1'b0);
    wr(`SACS_ADDR_CTRL, 8'h05);
    #1 chk(o_busy, 1'b0);
    wr(`SACS_ADDR_PCFG, 8'h20);
    // Every clock select, each on its own channel
    // Ideal comparator treats every bit period as long enough
    // RC run stands for a conversion with the core asleep
    for (int s = 0; s < 4; s++) begin
      h = (s == 0) ? 1 : (s == 1) ? 4 : (s == 2) ? 16 : RC_H;
      // Divide-by-2 decisions outrun the synchronised comparator, so a rail level is used
      level = (s == 0) ? 10'h3FF : 10'h0A5 + 10'(s) * 10'h0C3;
      convert(2'(s), 3'(s + 1));
      chk(n >= 22 * h && n <= 24 * h + 4, 1'b1);
      rd(`SACS_ADDR_RESH, {6'h00, level[9:8]});
      rd(`SACS_ADDR_RESL, level[7:0]);
      rd(`SACS_ADDR_FLAG, 8'h01);
      rd(`SACS_ADDR_CTRL, {2'(s), 3'(s + 1), 3'h1});
      wr(`SACS_ADDR_FLAG, 8'h00);
    end
    // Output pin driven high converts to full scale
    dir = 8'hDF;
    wr(`SACS_ADDR_DIR, 8'hDF);
    convert(2'h0, 3'h5);
    rd(`SACS_ADDR_RESL, 8'hFF);
    rd(`SACS_ADDR_RESH, 8'h03);
    dir = 8'hFF;
    wr(`SACS_ADDR_DIR, 8'hFF);
    wr(`SACS_ADDR_FLAG, 8'h00);
    // Abort in mid-run keeps the old result and reopens acquisition
    level = 10'h123;
    wr(`SACS_ADDR_CTRL, 8'h95);
    repeat (40) @(posedge i_clk);
    #1 chk(o_dac_load, 1'b1);
    wr(`SACS_ADDR_CTRL, 8'h91);
    #1 chk(o_busy, 1'b0);
    chk(o_dac_load, 1'b0);
    repeat (100) @(posedge i_clk);
    rd(`SACS_ADDR_RESL, 8'hFF);
    rd(`SACS_ADDR_FLAG, 8'h00);
    #1 chk(o_sample_connect, 1'b1);
    chk(o_mux_sel, 3'h2);
    // Switch divide-by-32 to divide-by-2 in mid-run, staying on the oscillator
    wr(`SACS_ADDR_CTRL, 8'h85);
    repeat (200) @(posedge i_clk);
    wr(`SACS_ADDR_CTRL, 8'h05);
    busy_len(n);
    chk(n >= 8 && n <= 16, 1'b1);
    rd(`SACS_ADDR_FLAG, 8'h01);
    // Analog pins read low, digital ones show the pad
    rd(`SACS_ADDR_PORT, 8'h00);
    wr(`SACS_ADDR_PCFG, 8'h26);
    rd(`SACS_ADDR_PORT, 8'hFF);
    rd(4'hF, 8'h00);
    // Left-justified result with the done enable set
    wr(`SACS_ADDR_PCFG, 8'h00);
    wr(`SACS_ADDR_FLAG, 8'h02);
    level = 10'h2C6;
    convert(2'h1, 3'h3);
    rd(`SACS_ADDR_RESH, level[9:2]);
    rd(`SACS_ADDR_RESL, {level[1:0], 6'h00});
    rd(`SACS_ADDR_FLAG, 8'h03);
    wrap_up;
  end
endmodule // tb_sar_adc_clock_and_sequencing
